// ==== hdl/irseq_cfg.svh ====
// constants for the infrared secondary link sequencer
`ifndef IRSEQ_CFG_SVH
`define IRSEQ_CFG_SVH
`define IRSEQ_CLK_HZ 40000000
`define IRSEQ_BAUD 9600
`define IRSEQ_BAUD_DIV (`IRSEQ_CLK_HZ / `IRSEQ_BAUD)
`define IRSEQ_IDLE_S 10
`define IRSEQ_IDLE_CYC (`IRSEQ_IDLE_S * `IRSEQ_CLK_HZ)
`define IRSEQ_DISC_CYC 120000000
`define IRSEQ_KEEP_CYC 20000000
`define IRSEQ_SVC_MODEM 8'h01
`define IRSEQ_RATE_9600 8'h02
`define IRSEQ_SLOT0 8'h00
`endif

// ==== hdl/irseq_pkg.sv ====
// types for the infrared secondary link sequencer
package irseq_pkg;
    typedef enum logic [3:0] {
        IRSEQ_F_NONE = 4'h0,
        IRSEQ_F_XID = 4'h1,
        IRSEQ_F_BCAST_ID = 4'h2,
        IRSEQ_F_SNRM = 4'h3,
        IRSEQ_F_IAS_OPEN = 4'h4,
        IRSEQ_F_IAS_QUERY = 4'h5,
        IRSEQ_F_DATA_OPEN = 4'h6,
        IRSEQ_F_DATA = 4'h7,
        IRSEQ_F_DISC = 4'h8
    } irseq_frame_e;
    typedef enum logic [3:0] {
        IRSEQ_R_NONE = 4'h0,
        IRSEQ_R_XID = 4'h1,
        IRSEQ_R_UA = 4'h2,
        IRSEQ_R_IAS_CONF = 4'h3,
        IRSEQ_R_IAS_ANS = 4'h4,
        IRSEQ_R_DATA_CONF = 4'h5,
        IRSEQ_R_RR = 4'h6,
        IRSEQ_R_RNR = 4'h7,
        IRSEQ_R_DATA = 4'h8,
        IRSEQ_R_CLOSE_CONF = 4'h9
    } irseq_resp_e;
    typedef enum logic [2:0] {
        IRSEQ_S_NDM = 3'b000,
        IRSEQ_S_CLAIMED = 3'b001,
        IRSEQ_S_DISCOVERY = 3'b010,
        IRSEQ_S_IAS = 3'b011,
        IRSEQ_S_CONNECTED = 3'b100
    } irseq_state_e;
endpackage

// ==== hdl/irseq_sequencer.sv ====
// connection-state sequencer for an infrared secondary station
`timescale 1ns/10ps
`include "irseq_cfg.svh"
module irseq_sequencer #(
    parameter logic [31:0] IDLE_CYC = `IRSEQ_IDLE_CYC,
    parameter logic [31:0] DISC_CYC = `IRSEQ_DISC_CYC,
    parameter logic [31:0] KEEP_CYC = `IRSEQ_KEEP_CYC
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic frame_valid_i,
    input wire irseq_pkg::irseq_frame_e frame_kind_i,
    input wire logic [7:0] frame_slot_i,
    input wire logic frame_crc_ok_i,
    input wire logic host_buf_full_i,
    input wire logic host_data_pending_i,
    input wire logic resp_ready_i,
    output logic resp_valid_o,
    output irseq_pkg::irseq_resp_e resp_kind_o,
    output logic [7:0] resp_param_o,
    output logic rx_deliver_o,
    output logic bit_tick_o,
    output logic cts_n_o,
    output logic dsr_n_o,
    output logic ir_activity_indicator_o,
    output irseq_pkg::irseq_state_e state_o
);
    import irseq_pkg::*;

    // ----------------------------------------
    // state and counters
    // ----------------------------------------
    irseq_state_e state_q, state_d;
    logic resp_valid_q, resp_valid_d;
    irseq_resp_e resp_kind_q, resp_kind_d;
    logic [7:0] resp_param_q, resp_param_d;
    logic rx_deliver_q;
    logic [31:0] idle_cnt_q;
    logic [31:0] disc_cnt_q;
    logic [31:0] keep_cnt_q;
    logic [15:0] baud_cnt_q;
    logic act_q;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire logic take = frame_valid_i & ~resp_valid_q;
    wire logic is_xid = take & (frame_kind_i == IRSEQ_F_XID);
    wire logic connected = (state_q == IRSEQ_S_CONNECTED);
    wire logic disc_expired = (disc_cnt_q >= DISC_CYC - 32'h1);
    wire logic keep_due = (keep_cnt_q >= KEEP_CYC - 32'h1);
    wire logic idle_expired = (idle_cnt_q >= IDLE_CYC - 32'h1);
    wire logic baud_wrap =
        (baud_cnt_q == 16'(`IRSEQ_BAUD_DIV - 1));
    wire logic data_good = take & connected
        & (frame_kind_i == IRSEQ_F_DATA) & frame_crc_ok_i;

    assign resp_valid_o = resp_valid_q;
    assign resp_kind_o = resp_kind_q;
    assign resp_param_o = resp_param_q;
    assign rx_deliver_o = rx_deliver_q;
    assign bit_tick_o = baud_wrap;
    assign state_o = state_q;
    assign ir_activity_indicator_o = act_q;
    assign cts_n_o = ~connected | host_buf_full_i;
    assign dsr_n_o = ~connected;

    // ----------------------------------------
    // next state and response
    // ----------------------------------------
    always_comb
    begin
        state_d = state_q;
        resp_valid_d = resp_valid_q & ~resp_ready_i;
        resp_kind_d = resp_kind_q;
        resp_param_d = resp_param_q;
        if (take)
        begin
            case (state_q)
                IRSEQ_S_NDM:
                begin
                    if (is_xid && frame_slot_i == `IRSEQ_SLOT0)
                    begin
                        resp_valid_d = 1'b1;
                        resp_kind_d = IRSEQ_R_XID;
                        resp_param_d = `IRSEQ_SVC_MODEM;
                        state_d = IRSEQ_S_CLAIMED;
                    end
                end
                IRSEQ_S_CLAIMED:
                begin
                    // silent to later slots and broadcast
                    if (frame_kind_i == IRSEQ_F_BCAST_ID)
                        state_d = IRSEQ_S_DISCOVERY;
                end
                IRSEQ_S_DISCOVERY, IRSEQ_S_IAS:
                begin
                    if (frame_kind_i == IRSEQ_F_SNRM)
                    begin
                        resp_valid_d = 1'b1;
                        resp_kind_d = IRSEQ_R_UA;
                        resp_param_d = `IRSEQ_RATE_9600;
                    end
                    else if (frame_kind_i == IRSEQ_F_IAS_OPEN)
                    begin
                        resp_valid_d = 1'b1;
                        resp_kind_d = IRSEQ_R_IAS_CONF;
                        state_d = IRSEQ_S_IAS;
                    end
                    else if (frame_kind_i == IRSEQ_F_IAS_QUERY)
                    begin
                        resp_valid_d = 1'b1;
                        resp_kind_d = IRSEQ_R_IAS_ANS;
                        resp_param_d = `IRSEQ_SVC_MODEM;
                    end
                    else if (frame_kind_i == IRSEQ_F_DATA_OPEN)
                    begin
                        resp_valid_d = 1'b1;
                        resp_kind_d = IRSEQ_R_DATA_CONF;
                        state_d = IRSEQ_S_CONNECTED;
                    end
                    else if (frame_kind_i == IRSEQ_F_DISC)
                    begin
                        resp_valid_d = 1'b1;
                        resp_kind_d = IRSEQ_R_CLOSE_CONF;
                        state_d = IRSEQ_S_NDM;
                    end
                end
                IRSEQ_S_CONNECTED:
                begin
                    if (frame_kind_i == IRSEQ_F_DISC)
                    begin
                        resp_valid_d = 1'b1;
                        resp_kind_d = IRSEQ_R_CLOSE_CONF;
                        state_d = IRSEQ_S_NDM;
                    end
                    else if (frame_kind_i == IRSEQ_F_DATA)
                    begin
                        resp_valid_d = 1'b1;
                        resp_kind_d = host_buf_full_i ? IRSEQ_R_RNR
                            : IRSEQ_R_RR;
                        resp_param_d = {7'h00, frame_crc_ok_i};
                    end
                end
                default:
                    state_d = IRSEQ_S_NDM;
            endcase
        end
        else if (connected && keep_due && !resp_valid_q)
        begin
            resp_valid_d = 1'b1;
            resp_kind_d = host_data_pending_i ? IRSEQ_R_DATA
                : IRSEQ_R_RR;
            resp_param_d = 8'h00;
        end
        if (state_q != IRSEQ_S_NDM && disc_expired && !take)
            state_d = IRSEQ_S_NDM;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q <= IRSEQ_S_NDM;
            resp_valid_q <= 1'b0;
            resp_kind_q <= IRSEQ_R_NONE;
            resp_param_q <= 8'h00;
            rx_deliver_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            resp_valid_q <= resp_valid_d;
            resp_kind_q <= resp_kind_d;
            resp_param_q <= resp_param_d;
            rx_deliver_q <= data_good;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            baud_cnt_q <= 16'h0000;
        else if (baud_wrap)
            baud_cnt_q <= 16'h0000;
        else
            baud_cnt_q <= baud_cnt_q + 16'h0001;
    end

    // frame silence timers
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            idle_cnt_q <= 32'h0;
            disc_cnt_q <= 32'h0;
            keep_cnt_q <= 32'h0;
        end
        else
        begin
            idle_cnt_q <= frame_valid_i ? 32'h0
                : (idle_expired ? idle_cnt_q : idle_cnt_q + 32'h1);
            disc_cnt_q <= (frame_valid_i || state_q == IRSEQ_S_NDM)
                ? 32'h0
                : (disc_expired ? disc_cnt_q : disc_cnt_q + 32'h1);
            keep_cnt_q <= (!connected || take || resp_valid_q) ? 32'h0
                : (keep_due ? keep_cnt_q : keep_cnt_q + 32'h1);
        end
    end

    // activity indicator
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            act_q <= 1'b0;
        else if (frame_valid_i && frame_kind_i == IRSEQ_F_XID)
            act_q <= 1'b1;
        else if (idle_expired)
            act_q <= 1'b0;
    end
endmodule

// ==== dv/irseq_sink.sv ====
// response sink model, prompt or slow
`timescale 1ns/10ps
module irseq_sink (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic valid_i,
    input wire irseq_pkg::irseq_resp_e kind_i,
    input wire logic [7:0] param_i,
    input wire logic [3:0] delay_i,
    output logic ready_o,
    output irseq_pkg::irseq_resp_e kind_o,
    output logic [7:0] param_o,
    output int cnt_o
);
    import irseq_pkg::*;
    logic [3:0] wait_q;
    assign ready_o = valid_i && wait_q >= delay_i;
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wait_q <= 4'h0;
            cnt_o <= 0;
            kind_o <= IRSEQ_R_NONE;
            param_o <= 8'h00;
        end
        else if (ready_o)
        begin
            wait_q <= 4'h0;
            cnt_o <= cnt_o + 1;
            kind_o <= kind_i;
            param_o <= param_i;
        end
        else if (valid_i)
            wait_q <= wait_q + 4'h1;
    end
endmodule

// ==== dv/irseq_checker.sv ====
// assertion checker for the link sequencer ports
`timescale 1ns/10ps
module irseq_checker (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic frame_valid_i,
    input wire irseq_pkg::irseq_frame_e frame_kind_i,
    input wire logic [7:0] frame_slot_i,
    input wire logic frame_crc_ok_i,
    input wire logic host_buf_full_i,
    input wire logic resp_ready_i,
    input wire logic resp_valid_o,
    input wire irseq_pkg::irseq_resp_e resp_kind_o,
    input wire logic [7:0] resp_param_o,
    input wire logic rx_deliver_o,
    input wire logic cts_n_o,
    input wire logic dsr_n_o,
    input wire logic ir_activity_indicator_o,
    input wire irseq_pkg::irseq_state_e state_o
);
    import irseq_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    wire tk = frame_valid_i && !resp_valid_o;
    wire con = state_o == IRSEQ_S_CONNECTED;
    property p_dsr; dsr_n_o == !con; endproperty
    a_dsr: assert property (p_dsr) else $error("dsr");
    property p_cts; cts_n_o == !(con && !host_buf_full_i); endproperty
    a_cts: assert property (p_cts) else $error("cts");
    property p_hold; resp_valid_o && !resp_ready_i |=>
        resp_valid_o && $stable(resp_kind_o); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_xid; tk && frame_kind_i == IRSEQ_F_XID && !frame_slot_i
        && state_o == IRSEQ_S_NDM |=> resp_kind_o == IRSEQ_R_XID
        && resp_param_o == 8'h01 && ir_activity_indicator_o; endproperty
    a_xid: assert property (p_xid) else $error("xid");
    property p_late; state_o == IRSEQ_S_CLAIMED && tk |=> !resp_valid_o;
    endproperty
    a_late: assert property (p_late) else $error("late");
    property p_ua; tk && frame_kind_i == IRSEQ_F_SNRM && state_o ==
        IRSEQ_S_DISCOVERY |=> resp_kind_o == IRSEQ_R_UA
        && resp_param_o == 8'h02; endproperty
    a_ua: assert property (p_ua) else $error("ua");
    property p_good; con && tk && frame_kind_i == IRSEQ_F_DATA &&
        frame_crc_ok_i |=> rx_deliver_o ##1 !rx_deliver_o; endproperty
    a_good: assert property (p_good) else $error("good");
    property p_close; con && tk && frame_kind_i == IRSEQ_F_DISC |=>
        resp_kind_o == IRSEQ_R_CLOSE_CONF && !con; endproperty
    a_close: assert property (p_close) else $error("close");
endmodule
bind irseq_sequencer irseq_checker chk (.*);

// ==== dv/tb_top.sv ====
// self-checking bench for the link sequencer
`timescale 1ns/10ps
`include "irseq_cfg.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    import irseq_pkg::*;
    logic mclk_i = 1'h0, resetn_i = 1'h0, frame_valid_i = 1'h0;
    logic frame_crc_ok_i = 1'h1, host_buf_full_i = 1'h0, dl;
    logic host_data_pending_i = 1'h0, resp_ready_i, resp_valid_o;
    logic rx_deliver_o, bit_tick_o, cts_n_o, dsr_n_o, ir_activity_indicator_o;
    logic [7:0] frame_slot_i = 8'h00, resp_param_o, gp;
    logic [3:0] dly = 4'h0;
    irseq_frame_e frame_kind_i = IRSEQ_F_NONE;
    irseq_resp_e resp_kind_o, gk;
    irseq_state_e state_o;
    int cnt, n_mismatch = 0, checks_done = 0;
    irseq_sequencer #(.IDLE_CYC(200), .DISC_CYC(300), .KEEP_CYC(100)) DUT (.*);
    irseq_sink sink (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .valid_i(resp_valid_o), .kind_i(resp_kind_o), .param_i(resp_param_o),
        .delay_i(dly), .ready_o(resp_ready_i), .kind_o(gk), .param_o(gp),
        .cnt_o(cnt));
    initial
    begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    task automatic frm(irseq_frame_e k, irseq_resp_e r, logic [7:0] p,
        logic [7:0] s = 8'h00);
        int c;
        c = cnt;
        @(posedge mclk_i);
        frame_kind_i <= k;
        frame_slot_i <= s;
        frame_valid_i <= 1'h1;
        @(posedge mclk_i);
        frame_valid_i <= 1'h0;
        #1 dl = rx_deliver_o;
        repeat (8) @(posedge mclk_i);
        #1 `CHK(cnt - c, int'(r != IRSEQ_R_NONE))
        if (r != IRSEQ_R_NONE) `CHK(gk, r)
        if (r != IRSEQ_R_NONE && p != 8'hff) `CHK(gp, p)
    endtask
    task automatic t_link;
        frm(IRSEQ_F_XID, IRSEQ_R_NONE, 8'hff, 8'h03);
        frm(IRSEQ_F_XID, IRSEQ_R_XID, 8'h01);
        `CHK({state_o, ir_activity_indicator_o}, {IRSEQ_S_CLAIMED, 1'h1})
        frm(IRSEQ_F_XID, IRSEQ_R_NONE, 8'hff, 8'h01);
        frm(IRSEQ_F_BCAST_ID, IRSEQ_R_NONE, 8'hff);
        `CHK({state_o, cts_n_o, dsr_n_o}, {IRSEQ_S_DISCOVERY, 2'h3})
        frm(IRSEQ_F_SNRM, IRSEQ_R_UA, 8'h02);
        frm(IRSEQ_F_IAS_OPEN, IRSEQ_R_IAS_CONF, 8'hff);
        frm(IRSEQ_F_IAS_QUERY, IRSEQ_R_IAS_ANS, 8'h01);
        frm(IRSEQ_F_DATA_OPEN, IRSEQ_R_DATA_CONF, 8'hff);
        `CHK({state_o, cts_n_o, dsr_n_o}, {IRSEQ_S_CONNECTED, 2'h0})
    endtask
    task automatic t_data;
        frm(IRSEQ_F_DATA, IRSEQ_R_RR, 8'h01);
        `CHK(dl, 1'h1)
        @(posedge mclk_i);
        frame_crc_ok_i <= 1'h0;
        frm(IRSEQ_F_DATA, IRSEQ_R_RR, 8'h00);
        `CHK(dl, 1'h0)
        @(posedge mclk_i);
        frame_crc_ok_i <= 1'h1;
        host_buf_full_i <= 1'h1;
        @(posedge mclk_i);
        #1 `CHK(cts_n_o, 1'h1)
        frm(IRSEQ_F_DATA, IRSEQ_R_RNR, 8'h01);
        @(posedge mclk_i);
        host_buf_full_i <= 1'h0;
        frm(IRSEQ_F_DISC, IRSEQ_R_CLOSE_CONF, 8'hff);
        `CHK({state_o, dsr_n_o}, {IRSEQ_S_NDM, 1'h1})
    endtask
    task automatic t_keep;
        repeat (110) @(posedge mclk_i);
        #1 `CHK(gk, IRSEQ_R_RR)
        `CHK(gp, 8'h00)
        @(posedge mclk_i);
        host_data_pending_i <= 1'h1;
        repeat (110) @(posedge mclk_i);
        #1 `CHK({gk, ir_activity_indicator_o}, {IRSEQ_R_DATA, 1'h0})
        repeat (110) @(posedge mclk_i);
        #1 `CHK(state_o, IRSEQ_S_NDM)
        `CHK(dsr_n_o, 1'h1)
    endtask
    // close request during the query phase
    task automatic t_abort;
        frm(IRSEQ_F_XID, IRSEQ_R_XID, 8'h01);
        `CHK(ir_activity_indicator_o, 1'h1)
        frm(IRSEQ_F_BCAST_ID, IRSEQ_R_NONE, 8'hff);
        frm(IRSEQ_F_SNRM, IRSEQ_R_UA, 8'h02);
        frm(IRSEQ_F_IAS_OPEN, IRSEQ_R_IAS_CONF, 8'hff);
        frm(IRSEQ_F_DISC, IRSEQ_R_CLOSE_CONF, 8'hff);
        `CHK({state_o, cts_n_o, dsr_n_o}, {IRSEQ_S_NDM, 2'h3})
    endtask
    // bit enable spacing
    task automatic t_tick;
        int n;
        n = 0;
        do
        begin
            @(posedge mclk_i);
            #1;
        end
        while (!bit_tick_o);
        do
        begin
            @(posedge mclk_i);
            #1 n++;
        end
        while (!bit_tick_o);
        `CHK(n, `IRSEQ_BAUD_DIV)
    endtask
    task automatic finish_test;
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge mclk_i);
        resetn_i <= 1'h1;
        dly <= 4'h3;
        t_link();
        t_data();
        @(posedge mclk_i);
        dly <= 4'h0;
        t_link();
        t_keep();
        t_abort();
        t_tick();
        finish_test();
    end
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        n_mismatch++;
        finish_test();
    end
endmodule
